// *** lbrs_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module lbrs_top (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst_b,
  // configuration access
  input  wire logic                   cfg_valid,
  input  wire lbrs_pkg::lbrs_cfg_s    cfg,
  output logic                        cfg_ack,
  output logic [31:0]                 cfg_rdata,
  output logic                        cfg_unmapped,
  // processor requests
  input  wire logic                   req_valid,
  input  wire lbrs_pkg::lbrs_req_s    req,
  output logic                        req_ready,
  // DRAM path
  output logic                        dram_valid,
  input  wire logic                   dram_ready,
  output lbrs_pkg::lbrs_req_s         dram_req,
  // south-bridge link
  output logic                        link_valid,
  input  wire logic                   link_ready,
  output lbrs_pkg::lbrs_req_s         link_req,
  // decode report of the held request
  output logic                        out_legacy_hit,
  output logic [lbrs_pkg::SEG_W-1:0]  out_seg,
  output logic [1:0]                  out_attr
);
  import lbrs_pkg::*;

  logic [31:0]        attr_low;
  logic [31:0]        attr_high;
  logic               dec_hit;
  logic [SEG_W-1:0]   dec_seg;
  logic [1:0]         dec_attr;
  lbrs_route_e        next_route;
  logic               take;
  logic               sel_ready;
  logic               hold_valid;
  lbrs_route_e        hold_route;
  lbrs_req_s          hold_req;
  logic               hold_hit;
  logic [SEG_W-1:0]   hold_seg;
  logic [1:0]         hold_attr;

  // ==========================================================
  // attribute registers
  lbrs_attr_regs u_regs (
    .clk_sys      (clk_sys),
    .rst_b        (rst_b),
    .cfg_valid    (cfg_valid),
    .cfg          (cfg),
    .cfg_ack      (cfg_ack),
    .cfg_rdata    (cfg_rdata),
    .cfg_unmapped (cfg_unmapped),
    .attr_low     (attr_low),
    .attr_high    (attr_high)
  );

  // ==========================================================
  // address decode of the incoming request
  lbrs_seg_decode u_dec (
    .addr      (req.addr),
    .attr_low  (attr_low),
    .attr_high (attr_high),
    .hit       (dec_hit),
    .seg       (dec_seg),
    .attr      (dec_attr)
  );

  // destination: attribute inside the window, plain DRAM outside it
  always_comb begin
    if (dec_hit) begin
      next_route = lbrs_route_of(dec_attr, req.write);
    end else begin
      next_route = ROUTE_DRAM;
    end
  end

  // ==========================================================
  // one-entry hold stage toward the two paths
  assign sel_ready = (hold_route == ROUTE_DRAM) ? dram_ready : link_ready;
  assign req_ready = !hold_valid || sel_ready;
  assign take      = req_valid && req_ready;

  // occupancy of the hold stage
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hold_valid <= 1'b0;
    end else begin
      hold_valid <= take || (hold_valid && !sel_ready);
    end
  end

  // capture of request and its decode; attributes sampled at this edge
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hold_req   <= '0;
      hold_route <= ROUTE_LINK;
      hold_hit   <= 1'b0;
      hold_seg   <= '0;
      hold_attr  <= 2'b00;
    end else if (take) begin
      hold_req   <= req;
      hold_route <= next_route;
      hold_hit   <= dec_hit;
      hold_seg   <= dec_seg;
      hold_attr  <= dec_attr;
    end
  end

  // path outputs, data straight from the hold flops
  assign dram_valid     = hold_valid && (hold_route == ROUTE_DRAM);
  assign link_valid     = hold_valid && (hold_route == ROUTE_LINK);
  assign dram_req       = hold_req;
  assign link_req       = hold_req;
  assign out_legacy_hit = hold_hit;
  assign out_seg        = hold_seg;
  assign out_attr       = hold_attr;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  logic first_cyc;

  // marks the first edge after reset release
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      first_cyc <= 1'b1;
    end else begin
      first_cyc <= 1'b0;
    end
  end

  sequence s_take_legacy(logic [1:0] a);
    take && dec_hit && (dec_attr == a);
  endsequence

  sequence s_take_blk(logic [ADDR_W-15:0] blk);
    take && (req.addr[ADDR_W-1:14] == blk);
  endsequence

  sequence s_cfg_low_wr;
    cfg_valid && cfg.write && (cfg.offset == ATTR_LOW_OFS);
  endsequence

  a_attr00_link: assert property (
    s_take_legacy(2'b00) |=> hold_valid && (hold_route == ROUTE_LINK) && !dram_valid)
    else $error("attribute 00 request not sent to link");

  a_attr01_split: assert property (
    s_take_legacy(2'b01) |=> hold_route == (hold_req.write ? ROUTE_LINK : ROUTE_DRAM))
    else $error("attribute 01 request misrouted");

  a_attr10_split: assert property (
    s_take_legacy(2'b10) |=> hold_route == (hold_req.write ? ROUTE_DRAM : ROUTE_LINK))
    else $error("attribute 10 request misrouted");

  a_attr11_dram: assert property (
    s_take_legacy(2'b11) |=> dram_valid && !link_valid)
    else $error("attribute 11 request not sent to DRAM");

  a_f0_field: assert property (
    take && (req.addr[ADDR_W-1:16] == 24'h00000f) |=> hold_attr == $past(attr_low[5:4]))
    else $error("0F0000 segment used wrong field");

  a_c0_field: assert property (
    s_take_blk(26'h30) |=> (hold_seg == 4'h1) && (hold_attr == $past(attr_low[9:8])))
    else $error("0C0000 segment used wrong field");

  a_c4_field: assert property (
    s_take_blk(26'h31) |=> hold_attr == $past(attr_low[13:12]))
    else $error("0C4000 segment used wrong field");

  a_c8_field: assert property (
    s_take_blk(26'h32) |=> hold_attr == $past(attr_low[17:16]))
    else $error("0C8000 segment used wrong field");

  a_cc_field: assert property (
    s_take_blk(26'h33) |=> hold_attr == $past(attr_low[21:20]))
    else $error("0CC000 segment used wrong field");

  a_d0_field: assert property (
    s_take_blk(26'h34) |=> hold_attr == $past(attr_low[25:24]))
    else $error("0D0000 segment used wrong field");

  a_d4_field: assert property (
    s_take_blk(26'h35) |=> hold_attr == $past(attr_low[29:28]))
    else $error("0D4000 segment used wrong field");

  a_d8_field: assert property (
    s_take_blk(26'h36) |=> hold_attr == $past(attr_high[1:0]))
    else $error("0D8000 segment used wrong field");

  a_dc_field: assert property (
    s_take_blk(26'h37) |=> hold_attr == $past(attr_high[5:4]))
    else $error("0DC000 segment used wrong field");

  a_e0_field: assert property (
    s_take_blk(26'h38) |=> hold_attr == $past(attr_high[9:8]))
    else $error("0E0000 segment used wrong field");

  a_e4_field: assert property (
    s_take_blk(26'h39) |=> hold_attr == $past(attr_high[13:12]))
    else $error("0E4000 segment used wrong field");

  a_e8_field: assert property (
    s_take_blk(26'h3a) |=> hold_attr == $past(attr_high[17:16]))
    else $error("0E8000 segment used wrong field");

  a_ec_field: assert property (
    s_take_blk(26'h3b) |=> (hold_seg == 4'hc) && (hold_attr == $past(attr_high[21:20])))
    else $error("0EC000 segment used wrong field");

  a_reset_clear: assert property (
    first_cyc |-> (attr_low == ATTR_RESET) && (attr_high == ATTR_RESET))
    else $error("attribute fields not cleared by reset");

  a_outside_plain: assert property (
    take && !dec_hit |=> !hold_hit && dram_valid)
    else $error("request outside window affected by attributes");

  a_new_attr_used: assert property (
    s_cfg_low_wr ##1 s_take_blk(26'h30) |=> hold_attr == $past(cfg.wdata[9:8], 2))
    else $error("written attribute not applied to next request");

  a_hold_stable: assert property (
    hold_valid && !sel_ready |=> hold_valid && $stable(hold_req) && $stable(hold_route))
    else $error("held request changed while stalled");

  a_one_path: assert property (
    !(dram_valid && link_valid))
    else $error("request offered to both paths");

  // ==========================================================
  // configuration port and hand-off checks
  sequence s_cfg_high_wr;
    cfg_valid && cfg.write && (cfg.offset == ATTR_HIGH_OFS);
  endsequence

  sequence s_cfg_read(logic [OFS_W-1:0] ofs);
    cfg_valid && !cfg.write && (cfg.offset == ofs);
  endsequence

  a_cfg_ack_next: assert property (
    cfg_valid |=> cfg_ack)
    else $error("config access not answered next cycle");

  a_cfg_ack_pulse: assert property (
    !cfg_valid |=> !cfg_ack)
    else $error("config answer without an access");

  a_unmapped_flag: assert property (
    cfg_valid |=> cfg_unmapped == $past((cfg.offset != ATTR_LOW_OFS) && (cfg.offset != ATTR_HIGH_OFS)))
    else $error("unmapped flag wrong for config offset");

  a_low_masked_wr: assert property (
    s_cfg_low_wr |=> attr_low == ($past(cfg.wdata) & ATTR_LOW_MASK))
    else $error("low attribute write not stored");

  a_high_masked_wr: assert property (
    s_cfg_high_wr |=> attr_high == ($past(cfg.wdata) & ATTR_HIGH_MASK))
    else $error("high attribute write not stored");

  a_low_readback: assert property (
    s_cfg_read(ATTR_LOW_OFS) |=> cfg_ack && (cfg_rdata == $past(attr_low)))
    else $error("low attribute read returned wrong data");

  a_high_readback: assert property (
    s_cfg_read(ATTR_HIGH_OFS) |=> cfg_ack && (cfg_rdata == $past(attr_high)))
    else $error("high attribute read returned wrong data");

  a_window_hit: assert property (
    take |=> hold_hit == $past((req.addr >= 40'h00_000c_0000) && (req.addr <= 40'h00_000f_ffff)))
    else $error("legacy window match wrong");

  a_attr_idle_miss: assert property (
    take && !dec_hit |=> hold_attr == 2'b00)
    else $error("attribute reported for request outside window");

  a_new_high_used: assert property (
    s_cfg_high_wr ##1 s_take_blk(26'h3b) |=> hold_attr == $past(cfg.wdata[21:20], 2))
    else $error("written high attribute not applied to next request");

  a_take_offers: assert property (
    take |=> dram_valid || link_valid)
    else $error("taken request not offered next cycle");

  a_req_forwarded: assert property (
    take |=> (dram_req == $past(req)) && (link_req == $past(req)))
    else $error("forwarded request differs from taken one");

  a_drain_clears: assert property (
    hold_valid && sel_ready && !take |=> !hold_valid)
    else $error("hold stage not emptied after hand-off");

  a_dram_stall_out: assert property (
    dram_valid && !dram_ready |=> dram_valid && $stable(dram_req))
    else $error("DRAM request dropped or changed while stalled");

  a_stall_refuse: assert property (
    dram_valid && !dram_ready |-> !req_ready)
    else $error("new request accepted while DRAM path stalled");

endmodule : lbrs_top
`default_nettype wire

// *** lbrs_pkg.sv ***
// How it works
// - attribute 00 sends every read and write of the region to the link
// - attribute 01 sends reads to DRAM and writes to the link
// - attribute 10 sends writes to DRAM and reads to the link
// - attribute 11 sends reads and writes to DRAM
// - low register bits 5:4 steer 0F0000 to 0FFFFF
// - low register bits 9:8 steer 0C0000 to 0C3FFF
// - low register bits 13:12 steer 0C4000 to 0C7FFF
// - low register bits 17:16 steer 0C8000 to 0CBFFF
// - low register bits 21:20 steer 0CC000 to 0CFFFF
// - low register bits 25:24 steer 0D0000 to 0D3FFF
// - low register bits 29:28 steer 0D4000 to 0D7FFF
// - high register bits 1:0 steer 0D8000 to 0DBFFF
// - high register bits 5:4 steer 0DC000 to 0DFFFF
// - high register bits 9:8 steer 0E0000 to 0E3FFF
// - high register bits 13:12 steer 0E4000 to 0E7FFF
// - high register bits 17:16 steer 0E8000 to 0EBFFF
// - high register bits 21:20 steer 0EC000 to 0EFFFF
// - all attribute fields are read/write and clear to zero on reset
package lbrs_pkg;

  // ==========================================================
  // widths and register map
  localparam int          ADDR_W          = 40;
  localparam int          TAG_W           = 8;
  localparam int          OFS_W           = 8;
  localparam int          NUM_SEGS        = 13;
  localparam int          SEG_W           = 4;
  localparam logic [7:0]  ATTR_LOW_OFS    = 8'h40;
  localparam logic [7:0]  ATTR_HIGH_OFS   = 8'h44;
  localparam logic [31:0] ATTR_LOW_MASK   = 32'h3333_3330;
  localparam logic [31:0] ATTR_HIGH_MASK  = 32'h0033_3333;
  localparam logic [31:0] ATTR_RESET      = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_RDATA  = 32'h0000_0000;

  // ==========================================================
  // legacy window layout: 0C0000..0FFFFF, 16 KB blocks below 0F0000
  localparam logic [1:0]  LEGACY_TOP_BITS = 2'b11;
  localparam logic [3:0]  SEG_F_NIBBLE    = 4'hf;
  localparam logic [SEG_W-1:0] SEG_F_INDEX = 4'h0;

  // register holding each segment field: 0 low, 1 high
  localparam logic [NUM_SEGS-1:0] SEG_IN_HIGH = 13'h1f80;

  // field lsb of each segment, index 0 is the 0F0000 segment
  localparam int SEG_LSB [NUM_SEGS] = '{
    4,
    8,
    12,
    16,
    20,
    24,
    28,
    0,
    4,
    8,
    12,
    16,
    20
  };

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    ATTR_LINK_ONLY  = 2'b00,
    ATTR_READ_DRAM  = 2'b01,
    ATTR_WRITE_DRAM = 2'b10,
    ATTR_ALL_DRAM   = 2'b11
  } lbrs_attr_e;

  typedef enum logic {
    ROUTE_LINK,
    ROUTE_DRAM
  } lbrs_route_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              write;
    logic [TAG_W-1:0]  tag;
  } lbrs_req_s;

  typedef struct packed {
    logic             write;
    logic [OFS_W-1:0] offset;
    logic [31:0]      wdata;
  } lbrs_cfg_s;

  // ==========================================================
  // destination for one access under one attribute
  function automatic lbrs_route_e lbrs_route_of(input logic [1:0] attr, input logic write);
    lbrs_route_e r;
    r = ROUTE_LINK;
    unique case (lbrs_attr_e'(attr))
      ATTR_LINK_ONLY:  r = ROUTE_LINK;
      ATTR_READ_DRAM:  r = write ? ROUTE_LINK : ROUTE_DRAM;
      ATTR_WRITE_DRAM: r = write ? ROUTE_DRAM : ROUTE_LINK;
      ATTR_ALL_DRAM:   r = ROUTE_DRAM;
    endcase
    return r;
  endfunction : lbrs_route_of

endpackage : lbrs_pkg

// *** lbrs_attr_regs.sv ***
`timescale 1ns/100ps
`default_nettype none
module lbrs_attr_regs (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  // configuration access
  input  wire logic              cfg_valid,
  input  wire lbrs_pkg::lbrs_cfg_s cfg,
  output logic                   cfg_ack,
  output logic [31:0]            cfg_rdata,
  output logic                   cfg_unmapped,
  // attribute fields
  output logic [31:0]            attr_low,
  output logic [31:0]            attr_high
);
  import lbrs_pkg::*;

  logic hit_low;
  logic hit_high;

  // ==========================================================
  // offset decode
  assign hit_low  = (cfg.offset == ATTR_LOW_OFS);
  assign hit_high = (cfg.offset == ATTR_HIGH_OFS);

  // attribute storage, only field bits are writable
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      attr_low  <= ATTR_RESET;
      attr_high <= ATTR_RESET;
    end else if (cfg_valid && cfg.write) begin
      if (hit_low) begin
        attr_low <= cfg.wdata & ATTR_LOW_MASK;
      end
      if (hit_high) begin
        attr_high <= cfg.wdata & ATTR_HIGH_MASK;
      end
    end
  end

  // answer one cycle after each access; reserved bits and holes read zero
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cfg_ack      <= 1'b0;
      cfg_rdata    <= UNMAPPED_RDATA;
      cfg_unmapped <= 1'b0;
    end else begin
      cfg_ack      <= cfg_valid;
      cfg_unmapped <= cfg_valid && !hit_low && !hit_high;
      if (cfg_valid && !cfg.write) begin
        cfg_rdata <= hit_low ? attr_low : (hit_high ? attr_high : UNMAPPED_RDATA);
      end
    end
  end

endmodule : lbrs_attr_regs
`default_nettype wire

// *** lbrs_seg_decode.sv ***
`timescale 1ns/100ps
`default_nettype none
module lbrs_seg_decode (
  // request address
  input  wire logic [lbrs_pkg::ADDR_W-1:0] addr,
  // attribute registers
  input  wire logic [31:0]                 attr_low,
  input  wire logic [31:0]                 attr_high,
  // decode result
  output logic                             hit,
  output logic [lbrs_pkg::SEG_W-1:0]       seg,
  output logic [1:0]                       attr
);
  import lbrs_pkg::*;

  logic [1:0] seg_attr [NUM_SEGS];

  // ==========================================================
  // pull each segment field out of its register
  for (genvar i = 0; i < NUM_SEGS; i++) begin : g_field
    assign seg_attr[i] = SEG_IN_HIGH[i] ? attr_high[SEG_LSB[i] +: 2]
                                        : attr_low[SEG_LSB[i] +: 2];
  end

  // window check: 0C0000..0FFFFF with nothing above bit 19
  assign hit = (addr[ADDR_W-1:20] == '0) && (addr[19:18] == LEGACY_TOP_BITS);

  // 0F segment is one 64 KB block; others are 16 KB blocks from 0C0000
  always_comb begin
    if (addr[19:16] == SEG_F_NIBBLE) begin
      seg = SEG_F_INDEX;
    end else begin
      seg = SEG_W'(addr[17:14]) + SEG_W'(1);
    end
  end

  // field of the matching segment only; 00 for anything outside the window
  always_comb begin
    attr = 2'b00;
    for (int k = 0; k < NUM_SEGS; k++) begin
      if (hit && (seg == SEG_W'(k))) begin
        attr = seg_attr[k];
      end
    end
  end

endmodule : lbrs_seg_decode
`default_nettype wire

// *** lbrs_sink.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// far side of one output path: takes requests, slow or prompt
module lbrs_sink (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst_b,
  // offered request
  input  wire logic                valid,
  input  wire lbrs_pkg::lbrs_req_s req,
  output logic                     ready,
  // behaviour and tally
  input  wire logic                slow,
  output logic [15:0]              taken,
  output logic [lbrs_pkg::TAG_W-1:0] last_tag
);
  import lbrs_pkg::*;
  logic [1:0] cnt;

  // free-running phase, ready only one cycle in four when slow; tally and last tag taken
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt      <= 2'h0;
      taken    <= 16'h0;
      last_tag <= '0;
    end else begin
      cnt <= cnt + 2'h1;
      if (valid && ready) begin
        taken    <= taken + 16'h1;
        last_tag <= req.tag;
      end
    end
  end

  assign ready = !slow || (cnt == 2'h3);
endmodule : lbrs_sink
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import lbrs_pkg::*;
  logic             clk_sys = 1'b0;
  logic             rst_b = 1'b0;
  logic             cfg_valid = 1'b0;
  lbrs_cfg_s        cfg = '0;
  logic             cfg_ack, cfg_unmapped;
  logic [31:0]      cfg_rdata;
  logic             req_valid = 1'b0;
  lbrs_req_s        req = '0;
  logic             req_ready, dram_valid, dram_ready, link_valid, link_ready, out_legacy_hit;
  lbrs_req_s        dram_req, link_req;
  logic [SEG_W-1:0] out_seg;
  logic [1:0]       out_attr;
  logic [15:0]      dram_taken, link_taken, dram_exp, link_exp;
  logic [TAG_W-1:0] dram_tag, link_tag;
  logic [7:0]       tag_cnt;
  logic [31:0]      lo, hi;
  int               num_errors = 0;
  int               num_checks = 0;

  always #25 clk_sys = ~clk_sys;

  // ==========================================================
  // design and far-side models: DRAM stalls, link answers at once
  lbrs_top i_lbrs_top (.clk_sys(clk_sys), .rst_b(rst_b), .cfg_valid(cfg_valid), .cfg(cfg),
    .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .cfg_unmapped(cfg_unmapped), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .dram_valid(dram_valid), .dram_ready(dram_ready),
    .dram_req(dram_req), .link_valid(link_valid), .link_ready(link_ready), .link_req(link_req),
    .out_legacy_hit(out_legacy_hit), .out_seg(out_seg), .out_attr(out_attr));
  lbrs_sink u_dram (.clk_sys(clk_sys), .rst_b(rst_b), .valid(dram_valid), .req(dram_req),
    .ready(dram_ready), .slow(1'b1), .taken(dram_taken), .last_tag(dram_tag));
  lbrs_sink u_link (.clk_sys(clk_sys), .rst_b(rst_b), .valid(link_valid), .req(link_req),
    .ready(link_ready), .slow(1'b0), .taken(link_taken), .last_tag(link_tag));

  // ==========================================================
  // compare, verdict and bus tasks
  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : check

  task automatic complete_run();
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  // one config access, answer looked at in the cycle after it is taken
  task automatic cfg_rw(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                        input logic [31:0] exp, input logic unm);
    @(posedge clk_sys) #1;
    cfg_valid = 1'b1;
    cfg = '{write: wr, offset: ofs, wdata: wd};
    @(posedge clk_sys) #1;
    cfg_valid = 1'b0;
    check(64'({cfg_ack, cfg_unmapped}), 64'({1'b1, unm}), "config answer");
    if (!wr) check(64'(cfg_rdata), 64'(exp), "read data");
  endtask : cfg_rw

  // one request, held until taken, then followed to its path
  task automatic send(input logic [ADDR_W-1:0] a, input logic wr, input logic to_dram,
                      input logic hit, input logic [3:0] seg, input logic [1:0] at);
    lbrs_req_s r;
    int        n;
    r = '{addr: a, write: wr, tag: tag_cnt};
    tag_cnt++;
    if (to_dram) dram_exp++;
    else link_exp++;
    @(posedge clk_sys) #1;
    req_valid = 1'b1;
    req = r;
    @(negedge clk_sys);
    for (n = 0; n < 50 && req_ready !== 1'b1; n++) @(negedge clk_sys);
    @(posedge clk_sys) #1;
    req_valid = 1'b0;
    check(64'({dram_valid, link_valid}), 64'({to_dram, !to_dram}), "route");
    check(64'(to_dram ? dram_req : link_req), 64'(r), "forwarded request");
    check(64'({out_legacy_hit, out_attr}), 64'({hit, at}), "decode");
    if (hit) check(64'(out_seg), 64'(seg), "segment");
    @(negedge clk_sys);
    for (n = 0; n < 50 && (to_dram ? dram_ready : link_ready) !== 1'b1; n++) @(negedge clk_sys);
    @(posedge clk_sys) #1;
    check(64'(to_dram ? dram_tag : link_tag), 64'(r.tag), "taken tag");
  endtask : send

  function automatic int seg_lsb(input int s);
    return (s == 0) ? 4 : (s < 7) ? 4 + 4 * s : 4 * (s - 7);
  endfunction : seg_lsb

  function automatic logic [ADDR_W-1:0] seg_base(input int s);
    return (s == 0) ? 40'h0f_0000 : 40'h0c_0000 + 40'(s - 1) * 40'h4000;
  endfunction : seg_base

  // ==========================================================
  // main sequence
  initial begin
    tag_cnt = 8'h0;
    dram_exp = 16'h0;
    link_exp = 16'h0;
    repeat (6) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    cfg_rw(1'b0, ATTR_LOW_OFS, 32'h0, 32'h0, 1'b0);
    cfg_rw(1'b0, ATTR_HIGH_OFS, 32'h0, 32'h0, 1'b0);
    send(40'h0c_0000, 1'b1, 1'b0, 1'b1, 4'h1, 2'h0);
    send(40'h0b_ffff, 1'b0, 1'b1, 1'b0, 4'h0, 2'h0);
    send(40'h10_0000, 1'b1, 1'b1, 1'b0, 4'h0, 2'h0);
    send(40'h10_000c_0000, 1'b0, 1'b1, 1'b0, 4'h0, 2'h0);
    cfg_rw(1'b1, ATTR_LOW_OFS, 32'hffff_ffff, 32'h0, 1'b0);
    cfg_rw(1'b1, ATTR_HIGH_OFS, 32'hffff_ffff, 32'h0, 1'b0);
    cfg_rw(1'b0, ATTR_LOW_OFS, 32'h0, 32'h3333_3330, 1'b0);
    cfg_rw(1'b0, ATTR_HIGH_OFS, 32'h0, 32'h0033_3333, 1'b0);
    send(40'h0b_ffff, 1'b0, 1'b1, 1'b0, 4'h0, 2'h0);
    send(40'h10_000f_0000, 1'b1, 1'b1, 1'b0, 4'h0, 2'h0);
    cfg_rw(1'b1, 8'h48, 32'hffff_ffff, 32'h0, 1'b1);
    cfg_rw(1'b0, 8'h48, 32'h0, 32'h0, 1'b1);
    // every segment under every attribute, both edges of the range
    for (int s = 0; s < 13; s++) begin
      for (int a = 0; a < 4; a++) begin
        lo = 32'h0;
        hi = 32'h0;
        if (s < 7) lo[seg_lsb(s) +: 2] = 2'(a);
        else hi[seg_lsb(s) +: 2] = 2'(a);
        cfg_rw(1'b1, (s < 7) ? ATTR_HIGH_OFS : ATTR_LOW_OFS, (s < 7) ? hi : lo, 32'h0, 1'b0);
        // field write and a request to its segment on the very next edge
        fork
          cfg_rw(1'b1, (s < 7) ? ATTR_LOW_OFS : ATTR_HIGH_OFS, (s < 7) ? lo : hi, 32'h0, 1'b0);
          begin
            @(posedge clk_sys);
            send(seg_base(s), 1'b0, 1'(a), 1'b1, 4'(s), 2'(a));
          end
        join
        for (int k = 0; k < 4; k++) begin
          send(seg_base(s) + (k[1] ? ((s == 0) ? 40'hffff : 40'h3fff) : 40'h0), k[0],
               k[0] ? 1'(a >> 1) : 1'(a), 1'b1, 4'(s), 2'(a));
        end
        send(seg_base((s + 1) % 13), 1'b0, 1'b0, 1'b1, 4'((s + 1) % 13), 2'h0);
      end
    end
    repeat (2) @(posedge clk_sys);
    check(64'({dram_taken, link_taken}), 64'({dram_exp, link_exp}), "transfer totals");
    complete_run();
  end

  // hang guard, well beyond the expected run length
  initial begin
    #(50 * 20000);
    num_errors++;
    complete_run();
  end
endmodule : testbench
`default_nettype wire
